// ---- include/sfpc_pkg.sv ----
/*
  Constants, codes and types of the sector flash port controller.
  Assumes a 200 MHz controller clock and a byte-wide sector flash on the pins.
*/
package sfpc_pkg;
  // Timing, in the units of the printed figures
  localparam int CLK_NS = 5;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 100;
  localparam int T_REC_NS = 50;
  localparam int T_GAP_US = 150;
  localparam int T_POR_MS = 5;
  // Least times round up, longest times round down
  localparam int RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (T_GAP_US * 1000) / CLK_NS;
  localparam int POR_CYC = (T_POR_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  // Strobe falls two cycles after a load is taken; keep slack
  localparam int GAP_MARGIN = 4;
  localparam int CNT_W = 20;
  // Array geometry
  localparam int ADDR_W = 17;
  localparam int OFS_W = 7;
  localparam int DATA_W = 8;
  localparam logic [7:0] LOAD_CNT_MAX = 8'h80;
  localparam logic [1:0] SEQ_DATA = 2'h3;
  localparam logic [1:0] SEQ_LAST_UNLOCK = 2'h2;
  // Register word indices
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_RDATA = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_CFG = 3'h5;
  // Status and config fields
  localparam int ST_BUSY = 0;
  localparam int ST_PROG = 1;
  localparam int ST_POR_DONE = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_DONE = 5;
  localparam int ST_CNT_LSB = 8;
  localparam int CFG_LOCK = 0;
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic STROBE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_READ = 3'h1,
    OP_LOAD = 3'h2,
    OP_POLL = 3'h3,
    OP_LOCK = 3'h4
  } sfpc_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_PULSE = 2'h3,
    ST_REC = 2'h2
  } sfpc_state_type;
endpackage

// ---- hw/sfpc_sector_flash_ctrl.sv ----
/*
  Host controller for a byte-wide sector flash: Avalon-MM register slave on one
  side, chip select, output gate, write strobe, address and data pins on the other.
  Assumes the flash pins are synchronous to mclk and the bench resolves the data wire.
*/
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps

module sfpc_sector_flash_ctrl #(
  parameter int GAP_CYC_P = sfpc_pkg::GAP_CYC,
  parameter int POR_CYC_P = sfpc_pkg::POR_CYC,
  // Unlock addresses and data: arbitrary values, set for the part in use
  parameter logic [16:0] UNLOCK_ADDR0 = 17'h00000,
  parameter logic [16:0] UNLOCK_ADDR1 = 17'h00001,
  parameter logic [16:0] UNLOCK_ADDR2 = 17'h00002,
  parameter logic [7:0] UNLOCK_DATA0 = 8'h00,
  parameter logic [7:0] UNLOCK_DATA1 = 8'h01,
  parameter logic [7:0] UNLOCK_DATA2 = 8'h02
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [16:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n
);
  localparam int CW = sfpc_pkg::CNT_W;

  logic wait_ff, nxt_wait;
  logic [31:0] bus_rd_ff, nxt_bus_rd;
  logic [16:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;

  sfpc_pkg::sfpc_state_type state_ff, nxt_state;
  sfpc_pkg::sfpc_op_type op_ff, nxt_op;
  logic [CW-1:0] cnt_ff, nxt_cnt, gap_ff, nxt_gap, por_ff, nxt_por;
  logic [1:0] seq_ff, nxt_seq;
  logic ce_ff, nxt_ce, oe_ff, nxt_oe, we_ff, nxt_we, dqoe_n_ff, nxt_dqoe_n;
  logic [16:0] fa_ff, nxt_fa, last_addr_ff, nxt_last_addr;
  logic [7:0] dqo_ff, nxt_dqo, rd_ff, nxt_rd, load_cnt_ff, nxt_load_cnt;
  logic [9:0] sector_ff, nxt_sector;
  logic loading_ff, nxt_loading, prog_ff, nxt_prog, last7_ff, nxt_last7;
  logic prev6_ff, nxt_prev6, prev_ok_ff, nxt_prev_ok, last_cmd_ff, nxt_last_cmd;
  logic lock_ff, nxt_lock, refused_ff, nxt_refused, done_ff, nxt_done;

  logic bus_commit, cmd_wr, sts_wr, cfg_wr, is_read, por_done;
  logic [31:0] status;

  assign bus_commit = avs_write && !wait_ff;
  assign cmd_wr = bus_commit && (avs_address == sfpc_pkg::REG_CMD);
  assign sts_wr = bus_commit && (avs_address == sfpc_pkg::REG_STATUS);
  assign cfg_wr = bus_commit && (avs_address == sfpc_pkg::REG_CFG);
  assign is_read = (op_ff == sfpc_pkg::OP_READ) || (op_ff == sfpc_pkg::OP_POLL);
  assign por_done = (por_ff == CW'(POR_CYC_P));

  function automatic logic [16:0] pick_addr(input logic [1:0] s, input logic [16:0] a);
    logic [16:0] r;
    unique case (s)
      2'h0: r = UNLOCK_ADDR0;
      2'h1: r = UNLOCK_ADDR1;
      2'h2: r = UNLOCK_ADDR2;
      2'h3: r = a;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] pick_data(input logic [1:0] s, input logic [7:0] d);
    logic [7:0] r;
    unique case (s)
      2'h0: r = UNLOCK_DATA0;
      2'h1: r = UNLOCK_DATA1;
      2'h2: r = UNLOCK_DATA2;
      2'h3: r = d;
    endcase
    return r;
  endfunction

  // Bus slave: one wait cycle, then a single acknowledge cycle
  always_comb begin
    status = 32'h00000000;
    status[sfpc_pkg::ST_BUSY] = (state_ff != sfpc_pkg::ST_IDLE);
    status[sfpc_pkg::ST_PROG] = prog_ff;
    status[sfpc_pkg::ST_POR_DONE] = por_done;
    status[sfpc_pkg::ST_REFUSED] = refused_ff;
    status[sfpc_pkg::ST_LOCK] = lock_ff;
    status[sfpc_pkg::ST_DONE] = done_ff;
    status[sfpc_pkg::ST_CNT_LSB +: 8] = load_cnt_ff;
    nxt_wait = 1'b1;
    nxt_bus_rd = bus_rd_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    if ((avs_read || avs_write) && wait_ff) begin
      nxt_wait = 1'b0;
      unique case (avs_address)
        sfpc_pkg::REG_ADDR: nxt_bus_rd = {15'h0000, addr_ff};
        sfpc_pkg::REG_WDATA: nxt_bus_rd = {24'h000000, wdata_ff};
        sfpc_pkg::REG_RDATA: nxt_bus_rd = {24'h000000, rd_ff};
        sfpc_pkg::REG_STATUS: nxt_bus_rd = status;
        sfpc_pkg::REG_CFG: nxt_bus_rd = {31'h00000000, lock_ff};
        default: nxt_bus_rd = 32'h00000000;
      endcase
    end
    if (bus_commit && avs_address == sfpc_pkg::REG_ADDR) begin
      nxt_addr = avs_writedata[16:0];
    end
    if (bus_commit && avs_address == sfpc_pkg::REG_WDATA) begin
      nxt_wdata = avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_ff <= 1'b1;
      bus_rd_ff <= 32'h00000000;
      addr_ff <= sfpc_pkg::ADDR_RST;
      wdata_ff <= sfpc_pkg::DATA_RST;
    end else begin
      wait_ff <= nxt_wait;
      bus_rd_ff <= nxt_bus_rd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  // Pin engine, load-period timer and polling
  always_comb begin
    sfpc_pkg::sfpc_op_type cmd_op;
    logic accept, gap_ok, sector_ok;
    logic [1:0] start_seq, seq_nx;
    cmd_op = sfpc_pkg::sfpc_op_type'(avs_writedata[2:0]);
    accept = 1'b0;
    gap_ok = (gap_ff + CW'(sfpc_pkg::GAP_MARGIN)) < CW'(GAP_CYC_P);
    sector_ok = (addr_ff[16:sfpc_pkg::OFS_W] == sector_ff) || (load_cnt_ff == 8'h00);
    start_seq = sfpc_pkg::SEQ_DATA;
    seq_nx = seq_ff + 2'h1;
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_cnt = cnt_ff;
    nxt_seq = seq_ff;
    nxt_ce = ce_ff;
    nxt_oe = oe_ff;
    nxt_we = we_ff;
    nxt_fa = fa_ff;
    nxt_dqo = dqo_ff;
    nxt_dqoe_n = dqoe_n_ff;
    nxt_rd = rd_ff;
    nxt_loading = loading_ff;
    nxt_prog = prog_ff;
    nxt_load_cnt = load_cnt_ff;
    nxt_sector = sector_ff;
    nxt_last_addr = last_addr_ff;
    nxt_last7 = last7_ff;
    nxt_prev6 = prev6_ff;
    nxt_prev_ok = prev_ok_ff;
    nxt_last_cmd = last_cmd_ff;
    nxt_lock = lock_ff;
    nxt_refused = refused_ff;
    nxt_done = done_ff;
    nxt_gap = gap_ff;
    nxt_por = por_ff;
    if (!por_done) begin
      nxt_por = por_ff + 1'b1;
    end
    // Gap since the last strobe rise; expiry hands over to the device timer
    if (state_ff == sfpc_pkg::ST_PULSE) begin
      nxt_gap = '0;
    end else if (loading_ff) begin
      if (gap_ff == CW'(GAP_CYC_P - 1)) begin
        nxt_loading = 1'b0;
        nxt_prog = 1'b1;
        nxt_load_cnt = 8'h00;
        nxt_prev_ok = 1'b0;
        nxt_gap = '0;
      end else begin
        nxt_gap = gap_ff + 1'b1;
      end
    end
    if (state_ff == sfpc_pkg::ST_IDLE && cmd_wr) begin
      unique case (cmd_op)
        sfpc_pkg::OP_READ: accept = !loading_ff && !prog_ff;
        sfpc_pkg::OP_LOAD: accept = por_done && !prog_ff && (!loading_ff || (gap_ok && sector_ok));
        sfpc_pkg::OP_LOCK: accept = por_done && !prog_ff && !loading_ff;
        sfpc_pkg::OP_POLL: accept = prog_ff;
        default: accept = 1'b0;
      endcase
    end
    if (sts_wr && avs_writedata[sfpc_pkg::ST_REFUSED]) begin
      nxt_refused = 1'b0;
    end
    if (sts_wr && avs_writedata[sfpc_pkg::ST_DONE]) begin
      nxt_done = 1'b0;
    end
    if (cfg_wr) begin
      nxt_lock = avs_writedata[sfpc_pkg::CFG_LOCK];
    end
    // Set wins over a same-cycle clear
    if (cmd_wr && !accept) begin
      nxt_refused = 1'b1;
    end
    unique case (state_ff)
      sfpc_pkg::ST_IDLE: begin
        if (accept) begin
          if ((cmd_op == sfpc_pkg::OP_LOAD && lock_ff && !loading_ff) || cmd_op == sfpc_pkg::OP_LOCK) begin
            start_seq = 2'h0;
          end
          nxt_op = cmd_op;
          nxt_seq = start_seq;
          nxt_state = sfpc_pkg::ST_ADDR;
          nxt_cnt = '0;
          nxt_ce = 1'b0;
          nxt_fa = (cmd_op == sfpc_pkg::OP_POLL) ? last_addr_ff : pick_addr(start_seq, addr_ff);
          nxt_dqo = pick_data(start_seq, wdata_ff);
          nxt_dqoe_n = (cmd_op == sfpc_pkg::OP_READ) || (cmd_op == sfpc_pkg::OP_POLL);
        end
      end
      sfpc_pkg::ST_ADDR: begin
        nxt_state = sfpc_pkg::ST_PULSE;
        nxt_cnt = '0;
        if (is_read) begin
          nxt_oe = 1'b0;
        end else begin
          nxt_we = 1'b0;
        end
      end
      sfpc_pkg::ST_PULSE: begin
        if (cnt_ff == CW'((is_read ? sfpc_pkg::RD_CYC : sfpc_pkg::WP_CYC) - 1)) begin
          nxt_state = sfpc_pkg::ST_REC;
          nxt_cnt = '0;
          nxt_ce = sfpc_pkg::STROBE_IDLE;
          nxt_oe = sfpc_pkg::STROBE_IDLE;
          nxt_we = sfpc_pkg::STROBE_IDLE;
          if (is_read) begin
            nxt_rd = flash_dq_in;
            if (op_ff == sfpc_pkg::OP_POLL) begin
              // Bit seven true and bit six steady over two reads
              // Command-only cycle: array byte unknown, so bit six alone decides
              if ((flash_dq_in[7] == last7_ff || last_cmd_ff) && prev_ok_ff && flash_dq_in[6] == prev6_ff) begin
                nxt_prog = 1'b0;
                nxt_done = 1'b1;
              end
              nxt_prev6 = flash_dq_in[6];
              nxt_prev_ok = 1'b1;
            end
          end else begin
            nxt_loading = 1'b1;
            nxt_last_addr = fa_ff;
            nxt_last7 = dqo_ff[7];
            nxt_last_cmd = (seq_ff != sfpc_pkg::SEQ_DATA);
            if (seq_ff == sfpc_pkg::SEQ_DATA) begin
              if (load_cnt_ff == 8'h00) begin
                nxt_sector = fa_ff[16:sfpc_pkg::OFS_W];
              end
              if (load_cnt_ff != sfpc_pkg::LOAD_CNT_MAX) begin
                nxt_load_cnt = load_cnt_ff + 8'h01;
              end
            end
            if (op_ff == sfpc_pkg::OP_LOCK && seq_ff == sfpc_pkg::SEQ_LAST_UNLOCK) begin
              nxt_lock = 1'b1;
            end
          end
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      sfpc_pkg::ST_REC: begin
        if (cnt_ff == CW'(sfpc_pkg::REC_CYC - 1)) begin
          nxt_cnt = '0;
          nxt_dqoe_n = 1'b1;
          nxt_state = sfpc_pkg::ST_IDLE;
          if (!is_read && (seq_ff < sfpc_pkg::SEQ_LAST_UNLOCK ||
              (seq_ff == sfpc_pkg::SEQ_LAST_UNLOCK && op_ff == sfpc_pkg::OP_LOAD))) begin
            nxt_seq = seq_nx;
            nxt_state = sfpc_pkg::ST_ADDR;
            nxt_ce = 1'b0;
            nxt_fa = pick_addr(seq_nx, addr_ff);
            nxt_dqo = pick_data(seq_nx, wdata_ff);
            nxt_dqoe_n = 1'b0;
          end else if (op_ff == sfpc_pkg::OP_POLL && prog_ff) begin
            nxt_state = sfpc_pkg::ST_ADDR;
            nxt_ce = 1'b0;
          end
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= sfpc_pkg::ST_IDLE;
      op_ff <= sfpc_pkg::OP_NONE;
      cnt_ff <= '0;
      gap_ff <= '0;
      por_ff <= '0;
      seq_ff <= sfpc_pkg::SEQ_DATA;
      ce_ff <= sfpc_pkg::STROBE_IDLE;
      oe_ff <= sfpc_pkg::STROBE_IDLE;
      we_ff <= sfpc_pkg::STROBE_IDLE;
      dqoe_n_ff <= 1'b1;
      fa_ff <= sfpc_pkg::ADDR_RST;
      last_addr_ff <= sfpc_pkg::ADDR_RST;
      dqo_ff <= sfpc_pkg::DATA_RST;
      rd_ff <= sfpc_pkg::DATA_RST;
      load_cnt_ff <= 8'h00;
      sector_ff <= 10'h000;
      loading_ff <= 1'b0;
      prog_ff <= 1'b0;
      last7_ff <= 1'b0;
      prev6_ff <= 1'b0;
      prev_ok_ff <= 1'b0;
      last_cmd_ff <= 1'b0;
      lock_ff <= 1'b0;
      refused_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      gap_ff <= nxt_gap;
      por_ff <= nxt_por;
      seq_ff <= nxt_seq;
      ce_ff <= nxt_ce;
      oe_ff <= nxt_oe;
      we_ff <= nxt_we;
      dqoe_n_ff <= nxt_dqoe_n;
      fa_ff <= nxt_fa;
      last_addr_ff <= nxt_last_addr;
      dqo_ff <= nxt_dqo;
      rd_ff <= nxt_rd;
      load_cnt_ff <= nxt_load_cnt;
      sector_ff <= nxt_sector;
      loading_ff <= nxt_loading;
      prog_ff <= nxt_prog;
      last7_ff <= nxt_last7;
      prev6_ff <= nxt_prev6;
      prev_ok_ff <= nxt_prev_ok;
      last_cmd_ff <= nxt_last_cmd;
      lock_ff <= nxt_lock;
      refused_ff <= nxt_refused;
      done_ff <= nxt_done;
    end
  end

  assign avs_readdata = bus_rd_ff;
  assign avs_waitrequest = wait_ff;
  assign flash_ce_n = ce_ff;
  assign flash_oe_n = oe_ff;
  assign flash_we_n = we_ff;
  assign flash_addr = fa_ff;
  assign flash_dq_out = dqo_ff;
  assign flash_dq_oe_n = dqoe_n_ff;

  // Helper: length of each write strobe low phase
  logic [7:0] we_lo_cnt_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      we_lo_cnt_ff <= 8'h00;
    end else begin
      we_lo_cnt_ff <= flash_we_n ? 8'h00 : we_lo_cnt_ff + 8'h01;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_strobe_fall;
    $fell(flash_we_n);
  endsequence
  sequence s_held_low;
    (!flash_we_n && $stable(flash_addr) && $stable(flash_dq_out) && !flash_dq_oe_n) [*8];
  endsequence

  a_read_gate: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
    else $error("read gate without select or with strobe low");
  a_no_fight: assert property (!flash_dq_oe_n |-> flash_oe_n && $past(flash_oe_n))
    else $error("data driven while flash output gate low");
  a_load_shape: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe low without select or with gate low");
  a_addr_hold: assert property (s_strobe_fall |-> s_held_low)
    else $error("address or data moved during write strobe");
  a_data_rise: assert property ($rose(flash_we_n) |-> !flash_dq_oe_n && $stable(flash_dq_out))
    else $error("data not held at strobe rise");
  a_pulse_width: assert property ($rose(flash_we_n) |-> we_lo_cnt_ff == 8'(sfpc_pkg::WP_CYC))
    else $error("write strobe low phase has wrong length");
  a_gap_close: assert property (loading_ff && gap_ff == CW'(GAP_CYC_P - 1) |=> prog_ff && !loading_ff)
    else $error("load period not closed at gap limit");
  a_sector_same: assert property (s_strobe_fall and (seq_ff == sfpc_pkg::SEQ_DATA && load_cnt_ff != 8'h00)
    |-> flash_addr[16:7] == sector_ff)
    else $error("sector lines changed within one load");
  a_prog_quiet: assert property (prog_ff |-> flash_we_n)
    else $error("write strobe during program time");
  a_por_block: assert property (!por_done |-> flash_we_n)
    else $error("write strobe before power-on delay");
  a_unlock_first: assert property (s_strobe_fall and (seq_ff == 2'h0) |-> flash_addr == UNLOCK_ADDR0
    && flash_dq_out == UNLOCK_DATA0)
    else $error("unlock sequence does not open with first command");
  a_poll_end: assert property ($fell(prog_ff) && !last_cmd_ff |-> done_ff && rd_ff[7] == last7_ff)
    else $error("program end declared without true bit seven");
  a_poll_done: assert property ($fell(prog_ff) |-> done_ff && op_ff == sfpc_pkg::OP_POLL)
    else $error("program end declared outside a poll");
endmodule

// ---- testbench/sfpc_flash_model.sv ----
/*
  Behavioural byte-wide sector flash on the controller's pins.
  Assumes strobes change only on mclk edges; the bench resolves the data wire.
*/
`timescale 1ns/100ps
module sfpc_flash_model #(
  parameter int GAP_CYC_P = 200,
  parameter int PROG_CYC_P = 300,
  parameter int POR_CYC_P = 40,
  parameter int ACC_CYC_P = 12
) (
  // Timing reference
  input wire logic mclk,
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [16:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic host_oe_n,
  output logic [7:0] dq_out,
  output logic dq_oe_n
);
  logic [7:0] mem [logic [16:0]];
  logic [16:0] qa [$];
  logic [7:0] qd [$];
  logic [16:0] lat_a;
  logic [7:0] last_d = 8'h00;
  logic lock_ff = 1'b0;
  logic prog_ff = 1'b0;
  logic loading = 1'b0;
  logic pulse = 1'b0;
  logic tog = 1'b0;
  logic viol_ff = 1'b0;
  int gap = 0;
  int pcnt = 0;
  int por = 0;
  int acc = 0;
  realtime t_fall;
  wire rd_on = !ce_n && !oe_n && we_n;
  assign dq_oe_n = !rd_on;
  initial dq_out = 8'h00;

  always @(negedge ce_n or negedge we_n) begin
    if (!ce_n && !we_n && oe_n) begin
      lat_a = addr;
      t_fall = $realtime;
      pulse = 1'b1;
    end else if (!ce_n && !we_n) begin
      viol_ff = 1'b1;
    end
  end

  always @(posedge ce_n or posedge we_n) begin
    if (pulse) begin
      pulse = 1'b0;
      if (prog_ff) begin
        viol_ff = 1'b1;
      end else if ($realtime - t_fall >= 15.0 && por >= POR_CYC_P) begin
        qa.push_back(lat_a);
        qd.push_back(dq_in);
        loading = 1'b1;
        gap = 0;
      end
    end
  end

  always @(negedge oe_n) begin
    if (prog_ff) begin
      tog = ~tog;
    end
  end

  // Unlock triple equals the controller's default parameter values
  task close_load;
    int n;
    bit unl;
    begin
      n = qa.size();
      unl = n >= 3;
      for (int i = 0; i < 3 && i < n; i++) begin
        unl &= qa[i] == 17'(i) && qd[i] == 8'(i);
      end
      if (unl && n == 3) begin
        lock_ff = 1'b1;
      end else if (unl || !lock_ff) begin
        for (int i = 0; i < 128; i++) begin
          mem[{qa[n-1][16:7], 7'(i)}] = 8'hFF;
        end
        for (int k = unl ? 3 : 0; k < n; k++) begin
          mem[qa[k]] = qd[k];
        end
      end
      last_d = qd[n-1];
      prog_ff = 1'b1;
      pcnt = 0;
      loading = 1'b0;
      qa.delete();
      qd.delete();
    end
  endtask

  always @(posedge mclk) begin
    if (por < POR_CYC_P) por++;
    acc = rd_on ? acc + 1 : 0;
    if (!host_oe_n && rd_on) viol_ff = 1'b1;
    // A strobe in progress holds the load period open
    if (loading && !pulse) gap++;
    if (loading && gap >= GAP_CYC_P) close_load();
    if (prog_ff) pcnt++;
    if (prog_ff && pcnt >= PROG_CYC_P) prog_ff = 1'b0;
    // Released wire keeps changing so a stale value is never read as data
    if (rd_on && acc > ACC_CYC_P) begin
      dq_out <= prog_ff ? {~last_d[7], tog, last_d[5:0]} : (mem.exists(addr) ? mem[addr] : 8'hFF);
    end else begin
      dq_out <= ~dq_out;
    end
  end
endmodule

// ---- testbench/sfpc_sector_flash_ctrl_tb_top.sv ----
/*
  Register-level bench of the sector flash controller with a flash model.
  Assumes shortened gap and power-on counts; gap 200 on both sides, power-on 50 in the controller and 40 in the model.
*/
`timescale 1ns/100ps
module sfpc_sector_flash_ctrl_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic flash_ce_n;
  logic flash_oe_n;
  logic flash_we_n;
  logic flash_dq_oe_n;
  logic m_oe_n;
  logic [16:0] flash_addr;
  logic [7:0] flash_dq_out;
  logic [7:0] m_dq;
  logic [7:0] dq_wire;
  logic [31:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign dq_wire = (flash_dq_oe_n === 1'b0) ? flash_dq_out : m_dq;

  sfpc_sector_flash_ctrl #(.GAP_CYC_P(200), .POR_CYC_P(50)) DUT (.mclk(mclk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_in(dq_wire),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));
  sfpc_flash_model #(.GAP_CYC_P(200)) M (.mclk(mclk), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .addr(flash_addr), .dq_in(dq_wire), .host_oe_n(flash_dq_oe_n), .dq_out(m_dq),
    .dq_oe_n(m_oe_n));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the longest sequence
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task xfer(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
        @(posedge mclk);
        n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    end
  endtask

  task st_wait(input int b, input logic v, input int lim);
    int n;
    begin
      n = 0;
      do begin
        xfer(1'b0, sfpc_pkg::REG_STATUS, 32'h0);
        n++;
      end while (q[b] !== v && n < lim);
      chk("status bit", 32'(v), 32'(q[b]));
    end
  endtask

  task cmd(input logic [2:0] op);
    xfer(1'b1, sfpc_pkg::REG_CMD, 32'(op));
    st_wait(sfpc_pkg::ST_BUSY, 1'b0, 60);
  endtask

  task refused;
    st_wait(sfpc_pkg::ST_REFUSED, 1'b1, 2);
    xfer(1'b1, sfpc_pkg::REG_STATUS, 32'h1 << sfpc_pkg::ST_REFUSED);
  endtask

  task load_byte(input logic [16:0] a, input logic [7:0] d);
    xfer(1'b1, sfpc_pkg::REG_ADDR, 32'(a));
    xfer(1'b1, sfpc_pkg::REG_WDATA, 32'(d));
    cmd(sfpc_pkg::OP_LOAD);
  endtask

  task flash_rd(input logic [16:0] a, input logic [7:0] e);
    xfer(1'b1, sfpc_pkg::REG_ADDR, 32'(a));
    cmd(sfpc_pkg::OP_READ);
    xfer(1'b0, sfpc_pkg::REG_RDATA, 32'h0);
    chk("flash byte", 32'(e), q);
  endtask

  // Waits out the load gap, then polls the program time to its end
  task settle(input logic need);
    int n;
    begin
      n = 0;
      do begin
        xfer(1'b0, sfpc_pkg::REG_STATUS, 32'h0);
        n++;
      end while (q[sfpc_pkg::ST_PROG] !== 1'b1 && n < 120);
      if (need) chk("prog", 32'h1, 32'(q[sfpc_pkg::ST_PROG]));
      if (q[sfpc_pkg::ST_PROG] === 1'b1) begin
        xfer(1'b1, sfpc_pkg::REG_CMD, 32'(sfpc_pkg::OP_READ));
        refused();
        xfer(1'b1, sfpc_pkg::REG_CMD, 32'(sfpc_pkg::OP_POLL));
        st_wait(sfpc_pkg::ST_DONE, 1'b1, 400);
        chk("prog end", 32'h0, 32'(q[sfpc_pkg::ST_PROG]));
        xfer(1'b1, sfpc_pkg::REG_STATUS, 32'h1 << sfpc_pkg::ST_DONE);
      end else begin
        repeat (400) @(posedge mclk);
      end
    end
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    chk("idle pins", 32'hF, {28'h0, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n});
    nrst <= 1'b1;
    xfer(1'b0, sfpc_pkg::REG_CFG, 32'h0);
    chk("cfg reset", 32'h0, q);
    xfer(1'b0, sfpc_pkg::REG_CMD, 32'h0);
    chk("cmd read", 32'h0, q);
    xfer(1'b0, 3'h6, 32'h0);
    chk("unmapped", 32'h0, q);
    load_byte(17'h00280, 8'h11);
    refused();
    st_wait(sfpc_pkg::ST_POR_DONE, 1'b1, 40);
    cmd(3'h7);
    refused();
    cmd(sfpc_pkg::OP_POLL);
    refused();
    // Whole sector in descending order, one foreign-sector attempt inside
    for (int i = 127; i >= 0; i--) begin
      load_byte({10'h005, 7'(i)}, 8'(i) ^ 8'h5A);
      if (i == 127) begin
        load_byte({10'h009, 7'h00}, 8'hEE);
        refused();
      end
    end
    xfer(1'b0, sfpc_pkg::REG_STATUS, 32'h0);
    chk("load count", 32'h80, 32'(q[15:8]));
    settle(1'b1);
    for (int i = 0; i < 128; i += 42) begin
      flash_rd({10'h005, 7'(i)}, 8'(i) ^ 8'h5A);
    end
    xfer(1'b1, sfpc_pkg::REG_CFG, 32'h1);
    cmd(sfpc_pkg::OP_LOCK);
    xfer(1'b0, sfpc_pkg::REG_STATUS, 32'h0);
    chk("lock mirror", 32'h1, 32'(q[sfpc_pkg::ST_LOCK]));
    settle(1'b0);
    chk("device lock", 32'h1, 32'(M.lock_ff));
    load_byte({10'h006, 7'h03}, 8'h12);
    settle(1'b1);
    flash_rd({10'h006, 7'h03}, 8'h12);
    xfer(1'b1, sfpc_pkg::REG_CFG, 32'h0);
    load_byte({10'h006, 7'h03}, 8'h34);
    settle(1'b1);
    flash_rd({10'h006, 7'h03}, 8'h12);
    chk("model faults", 32'h0, 32'(M.viol_ff));
    final_report();
  end
endmodule
